/* design/serial_frame_dram_map.svh */
// constants of the serial frame memory core: geometry, timing, reset values
`ifndef SERIAL_FRAME_DRAM_MAP_SVH
`define SERIAL_FRAME_DRAM_MAP_SVH

// ********************************************************
// address space
// ********************************************************
`define SFD_ADDR_W 18
`define SFD_ROW_LSB 0
`define SFD_ROW_W 9
`define SFD_COL_LSB 9
`define SFD_COL_W 9
`define SFD_ROWS 270
`define SFD_COLS 336
`define SFD_WORDS 90720
`define SFD_IDX_W 17
`define SFD_REF_ADDR_W 11
`define SFD_REF_COLS 4
`define SFD_REF_CYCLES 1080
`define SFD_REF_PERIOD_MS 4
`define SFD_REF_BITS 5376

// ********************************************************
// data layout
// ********************************************************
`define SFD_BYTE_W 8
`define SFD_SLOTS 8
`define SFD_WORD_W 64

// ********************************************************
// timing
// ********************************************************
`define SFD_CLK_PERIOD_NS 100
`define SFD_CRD_NS 140
`define SFD_CRD_CYC ((`SFD_CRD_NS + `SFD_CLK_PERIOD_NS - 1) / `SFD_CLK_PERIOD_NS)
`define SFD_CNT_W 4

// ********************************************************
// reset values
// ********************************************************
`define SFD_PIN_OE_N_RST 1'h1
`define SFD_PIN_DATA_RST 8'h00

`endif

/* design/serial_frame_dram_pkg.sv */
// types shared by the serial frame memory core
package serial_frame_dram_pkg;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_ACCESS,
    CYC_SKIP
  } cycle_state_t;

  // pin bundle seen from outside; strobes active low as on the pins
  typedef struct packed {
    logic cycle_strobe_n;
    logic chip_sel;
    logic write_enable_n;
    logic write_latch_strobe_n;
    logic read_latch_strobe_n;
    logic output_enable_n;
    logic serial_in_clock;
    logic serial_out_clock;
    logic output_force_low;
    logic port_direction_sel;
    logic [17:0] row_col_addr;
    logic [7:0] port_a_data;
    logic [7:0] port_b_data;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    cycle_state_t cyc;
    logic [16:0] idx;
    logic write_seen;
    logic [3:0] crd_cnt;
    logic [63:0] shift_in;
    logic [63:0] io_latch;
    logic [63:0] shift_out;
    logic [7:0] out_byte;
    logic [7:0] a_out;
    logic a_oe_n;
    logic [7:0] b_out;
    logic b_oe_n;
    logic refresh_pulse;
    logic [10:0] refresh_addr;
    logic timing_fault;
  } core_state_t;

endpackage : serial_frame_dram_pkg

/* design/frame_word_mem.sv */
// word array of the frame memory, registered read port
`timescale 1ns/10ps
module frame_word_mem #(
  parameter int DEPTH = 90720,
  parameter int IDX_W = 17,
  parameter int WORD_W = 64
) (
  input wire logic i_core_clk,
  input wire logic i_clk_en,
  input wire logic i_wr,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire logic [WORD_W-1:0] i_wr_data,
  input wire logic i_rd,
  input wire logic [IDX_W-1:0] i_rd_idx,
  output logic [WORD_W-1:0] o_rd_data
);

  logic [WORD_W-1:0] cells [DEPTH];

  // no reset: array contents are undefined at power up, as in the real part
  always_ff @(posedge i_core_clk)
  begin
    if (i_clk_en)
    begin
      if (i_wr)
      begin
        cells[i_wr_idx] <= i_wr_data;
      end
      if (i_rd)
      begin
        o_rd_data <= cells[i_rd_idx];
      end
    end
  end

endmodule : frame_word_mem

/* design/serial_frame_dram_core.sv */
// serial-access frame memory core: shift registers, strobe cycles, pin control
`timescale 1ns/10ps
`include "serial_frame_dram_map.svh"

// Summary of operation
// - each shift-in clock rise samples the input group into the 8-byte shift-in register
// - write strobe fall copies all eight shift-in bytes into the I/O latch
// - a write cycle stores the I/O latch, the last eight samples before strobe
// - read strobe fall latches array word into I/O latch and shift-out register
// - shift-out clock rises after read strobe emit eight bytes; later bytes undefined
// - cycle starts when cycle strobe falls with chip select high
// - write enable high gives read cycle, low gives write cycle
// - full row and column address captured at cycle strobe fall
// - shift-out data reaches pins only with output enable and force-low both low
// - refresh cycle by cycle strobe alone, rows 0-269, columns 0-3, 1080 per 4ms
// - refresh picks an address from low 11 bits and rewrites its 5376 bits
// - row field bits 0-8 below 270, column field bits 9-17 below 336
// - address outside implemented range performs no memory access
// - first serial sample sits in first slot and is shifted out first
// - pins float with output enable high; else forced low or carry data
// - direction select high: group a inputs, group b outputs; low reversed
// - each output byte holds until the next shift-out clock rise
// - output enable never gates shift-out register advance
module serial_frame_dram_core #(
  parameter int ROWS = `SFD_ROWS,
  parameter int COLS = `SFD_COLS,
  parameter int WORDS = `SFD_WORDS
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_cycle_strobe_n,
  input wire logic i_chip_sel,
  input wire logic i_write_enable_n,
  input wire logic i_write_latch_strobe_n,
  input wire logic i_read_latch_strobe_n,
  input wire logic i_output_enable_n,
  input wire logic i_serial_in_clock,
  input wire logic i_serial_out_clock,
  input wire logic i_output_force_low,
  input wire logic i_port_direction_sel,
  input wire logic [`SFD_ADDR_W-1:0] i_row_col_addr,
  input wire logic [`SFD_BYTE_W-1:0] i_port_a_data,
  output logic [`SFD_BYTE_W-1:0] o_port_a_data,
  output logic o_port_a_oe_n,
  input wire logic [`SFD_BYTE_W-1:0] i_port_b_data,
  output logic [`SFD_BYTE_W-1:0] o_port_b_data,
  output logic o_port_b_oe_n,
  output logic o_refresh_pulse,
  output logic [`SFD_REF_ADDR_W-1:0] o_refresh_addr,
  output logic o_timing_fault
);

  // ********************************************************
  // state
  // ********************************************************
  serial_frame_dram_pkg::core_state_t state;
  serial_frame_dram_pkg::core_state_t next_state;
  serial_frame_dram_pkg::pins_t pins_now;

  logic mem_wr;
  logic [`SFD_IDX_W-1:0] mem_wr_idx;
  logic [`SFD_WORD_W-1:0] mem_wr_data;
  logic mem_rd;
  logic [`SFD_IDX_W-1:0] mem_rd_idx;
  logic [`SFD_WORD_W-1:0] mem_rd_data;

  assign pins_now.cycle_strobe_n = i_cycle_strobe_n;
  assign pins_now.chip_sel = i_chip_sel;
  assign pins_now.write_enable_n = i_write_enable_n;
  assign pins_now.write_latch_strobe_n = i_write_latch_strobe_n;
  assign pins_now.read_latch_strobe_n = i_read_latch_strobe_n;
  assign pins_now.output_enable_n = i_output_enable_n;
  assign pins_now.serial_in_clock = i_serial_in_clock;
  assign pins_now.serial_out_clock = i_serial_out_clock;
  assign pins_now.output_force_low = i_output_force_low;
  assign pins_now.port_direction_sel = i_port_direction_sel;
  assign pins_now.row_col_addr = i_row_col_addr;
  assign pins_now.port_a_data = i_port_a_data;
  assign pins_now.port_b_data = i_port_b_data;

  // ********************************************************
  // next-state logic
  // ********************************************************
  always_comb
  begin
    logic ce_fall;
    logic ce_rise;
    logic wls_fall;
    logic rls_fall;
    logic sin_rise;
    logic soc_rise;
    logic [`SFD_ROW_W-1:0] row;
    logic [`SFD_COL_W-1:0] col;
    logic addr_ok;
    logic [`SFD_BYTE_W-1:0] sample;
    logic [`SFD_WORD_W-1:0] latch_now;
    ce_fall = 1'b0;
    ce_rise = 1'b0;
    wls_fall = 1'b0;
    rls_fall = 1'b0;
    sin_rise = 1'b0;
    soc_rise = 1'b0;
    row = '0;
    col = '0;
    addr_ok = 1'b0;
    sample = '0;
    latch_now = '0;
    next_state = state;
    mem_wr = 1'b0;
    mem_wr_idx = state.idx;
    mem_wr_data = '0;
    mem_rd = 1'b0;
    mem_rd_idx = '0;

    // pins pass two flops; edges come from the second and third stage only
    next_state.s1 = pins_now;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    ce_fall = state.s3.cycle_strobe_n & ~state.s2.cycle_strobe_n;
    ce_rise = ~state.s3.cycle_strobe_n & state.s2.cycle_strobe_n;
    wls_fall = state.s3.write_latch_strobe_n & ~state.s2.write_latch_strobe_n;
    rls_fall = state.s3.read_latch_strobe_n & ~state.s2.read_latch_strobe_n;
    sin_rise = ~state.s3.serial_in_clock & state.s2.serial_in_clock;
    soc_rise = ~state.s3.serial_out_clock & state.s2.serial_out_clock;

    next_state.refresh_pulse = 1'b0;
    next_state.timing_fault = 1'b0;

    // ********************************************************
    // serial input
    // ********************************************************
    sample = state.s2.port_direction_sel ? state.s2.port_a_data
                                         : state.s2.port_b_data;
    if (sin_rise)
    begin
      // newest byte enters the top so the first one ends in slot 0
      next_state.shift_in = {sample, state.shift_in[`SFD_WORD_W-1:`SFD_BYTE_W]};
    end
    latch_now = state.io_latch;
    if (wls_fall)
    begin
      latch_now = state.shift_in;
      next_state.io_latch = state.shift_in;
    end

    // ********************************************************
    // memory cycle
    // ********************************************************
    row = state.s2.row_col_addr[`SFD_ROW_LSB +: `SFD_ROW_W];
    col = state.s2.row_col_addr[`SFD_COL_LSB +: `SFD_COL_W];
    addr_ok = (32'(row) < ROWS) && (32'(col) < COLS);
    if (state.crd_cnt != '1)
    begin
      next_state.crd_cnt = state.crd_cnt + 4'h1;
    end
    case (state.cyc)
      serial_frame_dram_pkg::CYC_IDLE:
      begin
        if (ce_fall)
        begin
          next_state.crd_cnt = '0;
          next_state.write_seen = ~state.s2.write_enable_n;
          if (!state.s2.chip_sel)
          begin
            next_state.cyc = serial_frame_dram_pkg::CYC_SKIP;
          end
          else
          begin
            // any selected cycle with a real row refreshes it
            if (32'(row) < ROWS)
            begin
              next_state.refresh_pulse = 1'b1;
              next_state.refresh_addr = state.s2.row_col_addr[`SFD_REF_ADDR_W-1:0];
            end
            if (addr_ok)
            begin
              next_state.cyc = serial_frame_dram_pkg::CYC_ACCESS;
              next_state.idx = 17'(32'(col) * ROWS + 32'(row));
              mem_rd = 1'b1;
              mem_rd_idx = 17'(32'(col) * ROWS + 32'(row));
            end
            else
            begin
              next_state.cyc = serial_frame_dram_pkg::CYC_SKIP;
            end
          end
        end
      end
      serial_frame_dram_pkg::CYC_ACCESS:
      begin
        // write enable may fall late inside the cycle
        if (!state.s2.write_enable_n)
        begin
          next_state.write_seen = 1'b1;
        end
        if (rls_fall && !state.write_seen && state.s2.write_enable_n)
        begin
          if (state.crd_cnt < 4'(`SFD_CRD_CYC))
          begin
            next_state.timing_fault = 1'b1;
          end
          next_state.io_latch = mem_rd_data;
          next_state.shift_out = mem_rd_data;
        end
        if (ce_rise)
        begin
          next_state.cyc = serial_frame_dram_pkg::CYC_IDLE;
          if (state.write_seen || !state.s2.write_enable_n)
          begin
            mem_wr = 1'b1;
            mem_wr_data = latch_now;
          end
        end
      end
      serial_frame_dram_pkg::CYC_SKIP:
      begin
        if (ce_rise)
        begin
          next_state.cyc = serial_frame_dram_pkg::CYC_IDLE;
        end
      end
      default:
      begin
        next_state.cyc = serial_frame_dram_pkg::CYC_IDLE;
      end
    endcase

    // ********************************************************
    // serial output and pins
    // ********************************************************
    // advance ignores output enable; bytes past the eighth are zero here
    if (soc_rise && !rls_fall)
    begin
      next_state.out_byte = state.shift_out[`SFD_BYTE_W-1:0];
      next_state.shift_out = {8'h00, state.shift_out[`SFD_WORD_W-1:`SFD_BYTE_W]};
    end
    next_state.a_oe_n = 1'b1;
    next_state.b_oe_n = 1'b1;
    next_state.a_out = `SFD_PIN_DATA_RST;
    next_state.b_out = `SFD_PIN_DATA_RST;
    if (!state.s2.output_enable_n)
    begin
      if (state.s2.port_direction_sel)
      begin
        next_state.b_oe_n = 1'b0;
        next_state.b_out = state.s2.output_force_low ? 8'h00 : next_state.out_byte;
      end
      else
      begin
        next_state.a_oe_n = 1'b0;
        next_state.a_out = state.s2.output_force_low ? 8'h00 : next_state.out_byte;
      end
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state <= '0;
      state.a_oe_n <= `SFD_PIN_OE_N_RST;
      state.b_oe_n <= `SFD_PIN_OE_N_RST;
    end
    else if (i_clk_en)
    begin
      state <= next_state;
    end
  end

  // ********************************************************
  // array
  // ********************************************************
  frame_word_mem #(
    .DEPTH(WORDS),
    .IDX_W(`SFD_IDX_W),
    .WORD_W(`SFD_WORD_W)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_clk_en(i_clk_en),
    .i_wr(mem_wr),
    .i_wr_idx(mem_wr_idx),
    .i_wr_data(mem_wr_data),
    .i_rd(mem_rd),
    .i_rd_idx(mem_rd_idx),
    .o_rd_data(mem_rd_data)
  );

  assign o_port_a_data = state.a_out;
  assign o_port_a_oe_n = state.a_oe_n;
  assign o_port_b_data = state.b_out;
  assign o_port_b_oe_n = state.b_oe_n;
  assign o_refresh_pulse = state.refresh_pulse;
  assign o_refresh_addr = state.refresh_addr;
  assign o_timing_fault = state.timing_fault;

endmodule : serial_frame_dram_core

/* tb/serial_frame_dram_core_sva.sv */
// checker of the serial frame memory core ports
`timescale 1ns/10ps
`include "serial_frame_dram_map.svh"
module serial_frame_dram_core_sva (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_chip_sel,
  input wire logic i_output_enable_n,
  input wire logic i_serial_out_clock,
  input wire logic i_output_force_low,
  input wire logic [`SFD_ADDR_W-1:0] i_row_col_addr,
  input wire logic o_port_a_oe_n,
  input wire logic [`SFD_BYTE_W-1:0] o_port_b_data,
  input wire logic o_port_b_oe_n,
  input wire logic o_refresh_pulse,
  input wire logic [`SFD_REF_ADDR_W-1:0] o_refresh_addr
);
  // ****************
  // settling guard
  // ****************
  // sync stages reset to 0, so the pins may glitch just after release
  logic [2:0] up;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // ****************
  // assertions
  // ****************
  // pins reach the outputs three edges late: two sync stages and the output register
  oe_off_a: assert property (up == 3'h7 && $past(i_output_enable_n, 3) |->
    o_port_a_oe_n && o_port_b_oe_n) else $error("pin driven while disabled");
  oe_on_a: assert property (up == 3'h7 && !$past(i_output_enable_n, 3) |->
    o_port_a_oe_n != o_port_b_oe_n) else $error("no single group driven");
  excl_a: assert property (!o_port_a_oe_n |-> o_port_b_oe_n)
    else $error("both groups driven");
  force_low_a: assert property (up == 3'h7 && $past(i_output_force_low, 3) &&
    !o_port_b_oe_n |-> o_port_b_data == 8'h00) else $error("forced pins not low");
  byte_hold_a: assert property (up == 3'h7 && !o_port_b_oe_n && $past(!o_port_b_oe_n) &&
    !$past(i_output_force_low, 3) && !$past(i_output_force_low, 4) && $changed(o_port_b_data)
    |-> $past(i_serial_out_clock, 3) && !$past(i_serial_out_clock, 4))
    else $error("output byte changed without shift clock");
  ref_pulse_a: assert property (o_refresh_pulse |=> !o_refresh_pulse)
    else $error("refresh pulse too long");
  ref_addr_a: assert property (o_refresh_pulse |-> $past(i_chip_sel, 3) &&
    o_refresh_addr == $past(i_row_col_addr[10:0], 3)) else $error("refresh address wrong");
  ref_row_a: assert property (o_refresh_pulse |-> o_refresh_addr[8:0] < 9'h10e)
    else $error("refresh row out of range");
  cover property (o_refresh_pulse);
  cover property (!o_port_a_oe_n);
  cover property (!o_port_b_oe_n && $changed(o_port_b_data));
endmodule : serial_frame_dram_core_sva
bind serial_frame_dram_core serial_frame_dram_core_sva i_sva (.*);

/* tb/frame_ctrl_model.sv */
// frame memory controller model: strobes, address and serial clocks
`timescale 1ns/10ps
module frame_ctrl_model (
  input wire logic i_core_clk,
  output logic o_ce_n,
  output logic o_cs,
  output logic o_we_n,
  output logic o_wls_n,
  output logic o_rls_n,
  output logic o_sin_clk,
  output logic o_soc,
  output logic [17:0] o_addr,
  output logic [7:0] o_din
);
  initial
  begin
    {o_ce_n, o_we_n, o_wls_n, o_rls_n} = 4'hf;
    {o_cs, o_sin_clk, o_soc} = 3'h0;
    o_addr = 18'h00000;
    o_din = 8'h00;
  end
  // ****************
  // pin sequences, changed only at the falling clock edge
  // ****************
  // every level holds at least three cycles, above the two the synchroniser needs
  task automatic w(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : w
  task automatic wr(input logic [17:0] a, input logic [63:0] d, input logic c);
    for (int i = 0; i < 8; i++)
    begin
      o_din = d[8*i +: 8];
      o_sin_clk = 1'h1;
      w(3);
      o_sin_clk = 1'h0;
      o_din = 8'h00;
      w(3);
    end
    o_wls_n = 1'h0;
    w(3);
    o_wls_n = 1'h1;
    o_addr = a;
    o_cs = c;
    o_ce_n = 1'h0;
    o_we_n = 1'h0;
    w(3);
    o_addr = ~a;
    o_ce_n = 1'h1;
    w(3);
    o_we_n = 1'h1;
    o_cs = 1'h1;
    w(3);
  endtask : wr
  task automatic rd(input logic [17:0] a);
    o_addr = a;
    o_cs = 1'h1;
    // a normal access refreshes its row as well
    o_ce_n = 1'h0;
    w(3);
    o_addr = ~a;
    o_rls_n = 1'h0;
    w(3);
    o_rls_n = 1'h1;
    o_ce_n = 1'h1;
    w(4);
  endtask : rd
  task automatic so();
    o_soc = 1'h1;
    w(3);
    o_soc = 1'h0;
    w(3);
  endtask : so
  task automatic rf(input logic [17:0] a);
    o_addr = a;
    o_cs = 1'h1;
    o_ce_n = 1'h0;
    w(3);
    o_addr = ~a;
    o_ce_n = 1'h1;
    w(3);
  endtask : rf
endmodule : frame_ctrl_model

/* tb/serial_frame_dram_core_tb.sv */
// self-checking bench of the serial frame memory core
`timescale 1ns/10ps
module serial_frame_dram_core_tb;
  logic clk, nrst, oe_n, force_lo, dir;
  logic ce_n, cs, we_n, wls_n, rls_n, sin_clk, soc, a_oe_n, b_oe_n, rp, tf, clk_en;
  logic [17:0] addr;
  logic [7:0] din, pa, pb, a_out, b_out, outv;
  logic [10:0] ra, last;
  int err_count = 0;
  int checks_done = 0;
  int pc = 0;
  int fc = 0;
  // released data pins are pulled down
  assign pa = dir ? din : (a_oe_n ? 8'h00 : a_out);
  assign pb = dir ? (b_oe_n ? 8'h00 : b_out) : din;
  assign outv = dir ? b_out : a_out;
  serial_frame_dram_core i_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_clk_en(clk_en), .i_cycle_strobe_n(ce_n),
    .i_chip_sel(cs), .i_write_enable_n(we_n), .i_write_latch_strobe_n(wls_n),
    .i_read_latch_strobe_n(rls_n), .i_output_enable_n(oe_n), .i_serial_in_clock(sin_clk),
    .i_serial_out_clock(soc), .i_output_force_low(force_lo), .i_port_direction_sel(dir),
    .i_row_col_addr(addr), .i_port_a_data(pa), .o_port_a_data(a_out),
    .o_port_a_oe_n(a_oe_n), .i_port_b_data(pb), .o_port_b_data(b_out),
    .o_port_b_oe_n(b_oe_n), .o_refresh_pulse(rp), .o_refresh_addr(ra), .o_timing_fault(tf)
  );
  frame_ctrl_model i_ctl (
    .i_core_clk(clk), .o_ce_n(ce_n), .o_cs(cs), .o_we_n(we_n), .o_wls_n(wls_n),
    .o_rls_n(rls_n), .o_sin_clk(sin_clk), .o_soc(soc), .o_addr(addr), .o_din(din)
  );
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (rp === 1'h1)
    begin
      pc <= pc + 1;
      last <= ra;
    end
    if (tf === 1'h1)
    begin
      fc <= fc + 1;
    end
  end
  // ****************
  // checking and closing
  // ****************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic rdchk(input logic [17:0] a, input logic [63:0] d);
    i_ctl.rd(a);
    for (int i = 0; i < 9; i++)
    begin
      i_ctl.so();
      chk(64'(outv), 64'((i < 8) ? d[8*i +: 8] : 8'h00));
    end
  endtask : rdchk
  // ****************
  // scenarios
  // ****************
  task automatic t_rw();
    i_ctl.wr({9'h14f, 9'h10d}, 64'h8877665544332211, 1'h1);
    rdchk({9'h14f, 9'h10d}, 64'h8877665544332211);
  endtask : t_rw
  task automatic t_range();
    // row 270 of column 0 would alias row 0 of column 1 if it were not refused
    i_ctl.wr({9'h001, 9'h000}, 64'h0f1e2d3c4b5a6978, 1'h1);
    i_ctl.wr({9'h000, 9'h10e}, 64'hf0e1d2c3b4a59687, 1'h1);
    i_ctl.wr({9'h150, 9'h000}, 64'hf0e1d2c3b4a59687, 1'h1);
    rdchk({9'h001, 9'h000}, 64'h0f1e2d3c4b5a6978);
  endtask : t_range
  task automatic t_cs();
    i_ctl.wr({9'h001, 9'h000}, 64'h5566778899aabbcc, 1'h0);
    rdchk({9'h001, 9'h000}, 64'h0f1e2d3c4b5a6978);
  endtask : t_cs
  task automatic t_dir();
    dir = 1'h0;
    i_ctl.w(6);
    chk(64'(b_oe_n), 64'h1);
    i_ctl.wr({9'h002, 9'h007}, 64'h0123456789abcdef, 1'h1);
    rdchk({9'h002, 9'h007}, 64'h0123456789abcdef);
    dir = 1'h1;
    i_ctl.w(6);
  endtask : t_dir
  task automatic t_oe();
    i_ctl.rd({9'h002, 9'h007});
    oe_n = 1'h1;
    i_ctl.so();
    i_ctl.so();
    oe_n = 1'h0;
    i_ctl.so();
    chk(64'(outv), 64'hab);
  endtask : t_oe
  task automatic t_pins();
    oe_n = 1'h1;
    i_ctl.w(6);
    chk(64'({a_oe_n, b_oe_n}), 64'h3);
    oe_n = 1'h0;
    force_lo = 1'h1;
    i_ctl.w(6);
    chk(64'({b_oe_n, b_out}), 64'h000);
    force_lo = 1'h0;
    i_ctl.w(6);
    chk(64'(outv), 64'hab);
  endtask : t_pins
  // clock enable low freezes a whole write; the array also survives a reset
  task automatic t_hold();
    clk_en = 1'h0;
    i_ctl.wr({9'h002, 9'h007}, 64'hfedcba9876543210, 1'h1);
    clk_en = 1'h1;
    i_ctl.w(6);
    rdchk({9'h002, 9'h007}, 64'h0123456789abcdef);
    nrst = 1'h0;
    i_ctl.w(2);
    chk(64'({a_oe_n, b_oe_n, b_out}), 64'h300);
    nrst = 1'h1;
    i_ctl.w(6);
    rdchk({9'h002, 9'h007}, 64'h0123456789abcdef);
  endtask : t_hold
  task automatic t_ref();
    int p0;
    p0 = pc;
    i_ctl.rf({7'h00, 2'h3, 9'h10d});
    i_ctl.rf({9'h000, 9'h10e});
    chk(64'(pc - p0), 64'h1);
    chk(64'(last), 64'h7ff & {2'h3, 9'h10d});
    i_ctl.rd({9'h002, 9'h005});
    chk(64'(pc - p0), 64'h2);
    chk(64'(last), 64'h405);
    chk(64'(fc), 64'h0);
  endtask : t_ref
  initial
  begin
    nrst = 1'h0;
    oe_n = 1'h0;
    force_lo = 1'h0;
    dir = 1'h1;
    clk_en = 1'h1;
    repeat (16) @(negedge clk);
    nrst = 1'h1;
    i_ctl.w(6);
    t_rw();
    t_range();
    t_cs();
    t_dir();
    t_oe();
    t_pins();
    t_hold();
    t_ref();
    test_done();
  end
  // a run this short ends far inside the limit
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : serial_frame_dram_core_tb
